/* core/alarm_channel.sv */
// One alarm channel: static level or averaged rate-of-change test
`timescale 1ns/1ps
module alarm_channel
   import alarm_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              enable,
   input  wire logic              update,
   input  wire logic [DATA_W-1:0] sample,
   input  wire logic              rate_of_change_mode,
   input  wire logic [15:0]       threshold,
   input  wire logic [7:0]        sample_count,
   output logic                   hit,
   output logic                   level
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0]       prev;
      logic                    primed;
      logic signed [SUM_W-1:0] sum;
      logic [7:0]              cnt;
      logic                    hit;
      logic                    level;
   } chan_t;

   chan_t                   state_ff;
   chan_t                   nxt_state;
   logic signed [DATA_W:0]  delta;
   logic signed [SUM_W-1:0] acc;
   logic signed [SUM_W-1:0] avg;
   logic signed [SUM_W-1:0] mag_ext;
   logic signed [DATA_W-1:0] mag;
   logic [7:0]              n_eff;
   logic                    greater;

   assign mag     = $signed(threshold[MAG_MSB:0]);
   assign greater = threshold[DIR_BIT];

   // ----------------------------------------------------------------
   // Next state; a count of zero is taken as one to avoid a divide by zero
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state     = state_ff;
      nxt_state.hit = 1'b0;
      delta   = $signed({sample[DATA_W-1], sample}) - $signed({state_ff.prev[DATA_W-1], state_ff.prev});
      acc     = state_ff.sum + {{(SUM_W-DATA_W-1){delta[DATA_W]}}, delta};
      n_eff   = (sample_count == 8'h00) ? 8'h01 : sample_count;
      avg     = acc / $signed({16'h0000, n_eff});
      mag_ext = {{(SUM_W-DATA_W){mag[DATA_W-1]}}, mag};
      if (!enable) begin
         nxt_state = '0;
      end else if (update) begin
         nxt_state.prev   = sample;
         nxt_state.primed = 1'b1;
         if (!rate_of_change_mode) begin
            // Static level test against the raw magnitude
            nxt_state.sum   = '0;
            nxt_state.cnt   = 8'h00;
            nxt_state.level = greater ? ($signed(sample) > mag) : ($signed(sample) < mag);
            nxt_state.hit   = nxt_state.level;
         end else if (state_ff.primed) begin
            // Block average: verdict only when the window of deltas is full
            if ({1'b0, state_ff.cnt} + 9'h001 >= {1'b0, n_eff}) begin
               nxt_state.sum   = '0;
               nxt_state.cnt   = 8'h00;
               nxt_state.level = greater ? (avg > mag_ext) : (avg < mag_ext);
               nxt_state.hit   = nxt_state.level;
            end else begin
               nxt_state.sum = acc;
               nxt_state.cnt = state_ff.cnt + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign hit   = state_ff.hit;
   assign level = state_ff.level;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   static_gt_a: assert property (enable && update && !rate_of_change_mode && greater
                                 && ($signed(sample) > mag) |=> hit && level)
      else $error("static greater-than event missed");
   static_lt_a: assert property (enable && update && !rate_of_change_mode && !greater
                                 && ($signed(sample) >= mag) |=> !hit)
      else $error("static less-than fired wrongly");
   off_clear_a: assert property (!enable |=> !level && !hit)
      else $error("disabled channel still active");
   hit_on_update_a: assert property (hit |-> $past(update))
      else $error("event without sample update");

   roc_hit_c: cover property (rate_of_change_mode ##1 hit);

endmodule // alarm_channel

/* core/alarm_pkg.sv */
// Constants shared by the dual alarm condition monitor
package alarm_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [6:0] THR1_OFS   = 7'h26;
   localparam logic [6:0] THR2_OFS   = 7'h28;
   localparam logic [6:0] SMP1_OFS   = 7'h2A;
   localparam logic [6:0] SMP2_OFS   = 7'h2C;
   localparam logic [6:0] CTRL_OFS   = 7'h2E;
   localparam logic [6:0] STATUS_OFS = 7'h3C;

   // ----------------------------------------------------------------
   // Reset values and writable-bit masks
   // ----------------------------------------------------------------
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] THR_MASK  = 16'hBFFF;
   localparam logic [15:0] SMP_MASK  = 16'h00FF;
   localparam logic [15:0] CTRL_MASK = 16'hFFD7;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DIR_BIT     = 15;
   localparam int MAG_MSB     = 13;
   localparam int CNT_MSB     = 7;
   localparam int SRC2_LSB    = 12;
   localparam int SRC1_LSB    = 8;
   localparam int ROC1_BIT    = 6;
   localparam int FILT_BIT    = 4;
   localparam int OUT_EN_BIT  = 2;
   localparam int POL_BIT     = 1;
   localparam int LINE_BIT    = 0;
   localparam int ST_ALM1_BIT = 8;

   // ----------------------------------------------------------------
   // Sizes and source codes
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 11;
   localparam int DATA_W  = 14;
   localparam int SUM_W   = 24;
   localparam int NUM_CH  = 2;
   localparam logic [3:0] SRC_OFF  = 4'h0;
   localparam logic [3:0] SRC_LAST = 4'hB;

endpackage

/* core/dual_alarm_condition_monitor.sv */
// Dual alarm condition monitor: registers, source select, status and pin drive
`timescale 1ns/1ps
module dual_alarm_condition_monitor
   import alarm_pkg::*;
(
   input  wire logic                            clock,
   input  wire logic                            rst_b,
   input  wire logic [6:0]                      reg_addr,
   input  wire logic                            reg_wr,
   input  wire logic [15:0]                     reg_wdata,
   input  wire logic                            reg_rd,
   output logic      [15:0]                     reg_rdata,
   input  wire logic                            update,
   input  wire logic [NUM_SRC-1:0][DATA_W-1:0] raw_data,
   input  wire logic [NUM_SRC-1:0][DATA_W-1:0] filt_data,
   output logic                                 general_pin_one_out,
   output logic                                 general_pin_one_oe,
   output logic                                 general_pin_two_out,
   output logic                                 general_pin_two_oe
);

   // ----------------------------------------------------------------
   // State of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0][15:0] thr;
      logic [NUM_CH-1:0][15:0] smp;
      logic [15:0]             ctrl;
      logic [NUM_CH-1:0]       flags;
      logic [15:0]             rdata;
      logic                    p1_out;
      logic                    p1_oe;
      logic                    p2_out;
      logic                    p2_oe;
   } top_t;

   top_t              state_ff;
   top_t              nxt_state;
   logic [NUM_CH-1:0] ch_hit;
   logic [NUM_CH-1:0] ch_level;
   logic [NUM_CH-1:0] ch_enable;
   logic [NUM_CH-1:0] ch_roc;
   logic              any_active;
   logic              pin_value;
   logic              status_read;

   // ----------------------------------------------------------------
   // Channels: source pick and evaluation
   // ----------------------------------------------------------------
   // Codes above the last source are treated as disabled, so an
   // out-of-range code can never index past the sample array.
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic [3:0]        src_code;
      logic [3:0]        src_idx;
      logic [DATA_W-1:0] src_sample;

      assign src_code     = state_ff.ctrl[SRC1_LSB + 4*i +: 4];
      assign src_idx      = src_code - 4'h1;
      assign ch_enable[i] = (src_code != SRC_OFF) && (src_code <= SRC_LAST);
      assign ch_roc[i]    = state_ff.ctrl[ROC1_BIT + i];

      // Both channels share the filter choice
      always_comb begin
         if (!ch_enable[i]) begin
            src_sample = '0;
         end else if (state_ff.ctrl[FILT_BIT]) begin
            src_sample = filt_data[src_idx];
         end else begin
            src_sample = raw_data[src_idx];
         end
      end

      alarm_channel u_channel (
         .clock               (clock),
         .rst_b               (rst_b),
         .enable              (ch_enable[i]),
         .update              (update),
         .sample              (src_sample),
         .rate_of_change_mode (ch_roc[i]),
         .threshold           (state_ff.thr[i]),
         .sample_count        (state_ff.smp[i][CNT_MSB:0]),
         .hit                 (ch_hit[i]),
         .level               (ch_level[i])
      );
   end

   // ----------------------------------------------------------------
   // Pin level and status access
   // ----------------------------------------------------------------
   assign any_active  = |ch_level;
   assign pin_value   = state_ff.ctrl[POL_BIT] ? any_active : !any_active;
   assign status_read = reg_rd && (reg_addr == STATUS_OFS);

   // ----------------------------------------------------------------
   // Next state: register writes, read data, flags, pins
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;

      // Writes store only the implemented bits; others ignored
      if (reg_wr) begin
         unique case (reg_addr)
            THR1_OFS: nxt_state.thr[0] = reg_wdata & THR_MASK;
            THR2_OFS: nxt_state.thr[1] = reg_wdata & THR_MASK;
            SMP1_OFS: nxt_state.smp[0] = reg_wdata & SMP_MASK;
            SMP2_OFS: nxt_state.smp[1] = reg_wdata & SMP_MASK;
            CTRL_OFS: nxt_state.ctrl   = reg_wdata & CTRL_MASK;
            default:  nxt_state.ctrl   = state_ff.ctrl;
         endcase
      end

      // Read data is registered; unmapped addresses read zero
      if (reg_rd) begin
         unique case (reg_addr)
            THR1_OFS:   nxt_state.rdata = state_ff.thr[0];
            THR2_OFS:   nxt_state.rdata = state_ff.thr[1];
            SMP1_OFS:   nxt_state.rdata = state_ff.smp[0];
            SMP2_OFS:   nxt_state.rdata = state_ff.smp[1];
            CTRL_OFS:   nxt_state.rdata = state_ff.ctrl;
            STATUS_OFS: nxt_state.rdata = {6'h00, state_ff.flags, 8'h00};
            default:    nxt_state.rdata = 16'h0000;
         endcase
      end

      // A status read clears the flags; a new event in the same
      // cycle still sets its flag, so no event is lost
      if (status_read) begin
         nxt_state.flags = '0;
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (ch_hit[i]) begin
            nxt_state.flags[i] = 1'b1;
         end
      end

      // Only the selected pin is driven; the other stays released
      if (!state_ff.ctrl[OUT_EN_BIT]) begin
         nxt_state.p1_oe  = 1'b0;
         nxt_state.p1_out = 1'b0;
         nxt_state.p2_oe  = 1'b0;
         nxt_state.p2_out = 1'b0;
      end else if (state_ff.ctrl[LINE_BIT]) begin
         nxt_state.p1_oe  = 1'b0;
         nxt_state.p1_out = 1'b0;
         nxt_state.p2_oe  = 1'b1;
         nxt_state.p2_out = pin_value;
      end else begin
         nxt_state.p1_oe  = 1'b1;
         nxt_state.p1_out = pin_value;
         nxt_state.p2_oe  = 1'b0;
         nxt_state.p2_out = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff.thr    <= {REG_RESET, REG_RESET};
         state_ff.smp    <= {REG_RESET, REG_RESET};
         state_ff.ctrl   <= REG_RESET;
         state_ff.flags  <= '0;
         state_ff.rdata  <= 16'h0000;
         state_ff.p1_out <= 1'b0;
         state_ff.p1_oe  <= 1'b0;
         state_ff.p2_out <= 1'b0;
         state_ff.p2_oe  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign reg_rdata           = state_ff.rdata;
   assign general_pin_one_out = state_ff.p1_out;
   assign general_pin_one_oe  = state_ff.p1_oe;
   assign general_pin_two_out = state_ff.p2_out;
   assign general_pin_two_oe  = state_ff.p2_oe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   flag1_set_a: assert property (ch_hit[0] |=> state_ff.flags[0])
      else $error("alarm 1 flag not set");
   flag2_set_a: assert property (ch_hit[1] |=> state_ff.flags[1])
      else $error("alarm 2 flag not set");
   status_clear_a: assert property (status_read && !ch_hit[0] |=> !state_ff.flags[0])
      else $error("status read did not clear flag");
   status_bits_a: assert property (status_read |=> reg_rdata == {6'h00, $past(state_ff.flags), 8'h00})
      else $error("status read data wrong");
   pin_off_a: assert property (!state_ff.ctrl[OUT_EN_BIT] |=> !general_pin_one_oe && !general_pin_two_oe)
      else $error("pin driven while disabled");
   pin_line_a: assert property (state_ff.ctrl[OUT_EN_BIT] && state_ff.ctrl[LINE_BIT]
                                |=> general_pin_two_oe && !general_pin_one_oe)
      else $error("wrong alarm pin selected");
   pin_pol_a: assert property (state_ff.ctrl[OUT_EN_BIT] && !state_ff.ctrl[LINE_BIT]
                               |=> general_pin_one_out == ($past(any_active) == $past(state_ff.ctrl[POL_BIT])))
      else $error("alarm pin polarity wrong");
   src_off_a: assert property (state_ff.ctrl[SRC1_LSB +: 4] == SRC_OFF
                               |=> !ch_level[0])
      else $error("disabled alarm 1 still active");
   ctrl_write_a: assert property (reg_wr && reg_addr == CTRL_OFS
                                  |=> state_ff.ctrl == ($past(reg_wdata) & CTRL_MASK))
      else $error("control write not stored");
   thr_unused_a: assert property (reg_wr && reg_addr == THR1_OFS |=> !state_ff.thr[0][14])
      else $error("unused threshold bit stored");

   alarm1_c: cover property (ch_hit[0] ##1 status_read);
   alarm2_roc_c: cover property (ch_roc[1] && ch_hit[1]);
   pin_two_c: cover property (general_pin_two_oe && general_pin_two_out);

endmodule // dual_alarm_condition_monitor

/* verification/host_model.sv */
// Host processor model issuing register writes and reads
`timescale 1ns/1ps
module host_model (
   input  wire logic        clock,
   output logic      [6:0]  reg_addr,
   output logic             reg_wr,
   output logic      [15:0] reg_wdata,
   output logic             reg_rd,
   input  wire logic [15:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_addr  = 7'h00;
      reg_wr    = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd    = 1'b0;
   end

   // One strobe cycle; released lines show inverted values so stale data never looks live
   task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   // Read data is registered at the taking edge and stands, so it is taken at the next edge
   task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(posedge clock);
      d = reg_rdata;
   endtask
endmodule // host_model

/* verification/tb_top.sv */
// Self-checking testbench for the dual alarm condition monitor
`timescale 1ns/1ps
module tb_top
   import alarm_pkg::*;
;
   typedef logic [NUM_SRC-1:0][DATA_W-1:0] set_t;
   typedef struct packed {
      logic [3:0] src; logic filt; logic ch2; logic [15:0] thr;
      logic [13:0] val; logic [13:0] other; logic [15:0] exp;
   } row_t;
   logic        clock, rst_b, reg_wr, reg_rd, update;
   logic [6:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   set_t        raw_data, filt_data;
   logic        one_out, one_oe, two_out, two_oe;
   int          mismatches, cmp_count;
   row_t        rows [13];

   host_model HOST (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
                    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   dual_alarm_condition_monitor DUT (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .update(update),
      .raw_data(raw_data), .filt_data(filt_data), .general_pin_one_out(one_out),
      .general_pin_one_oe(one_oe), .general_pin_two_out(two_out), .general_pin_two_oe(two_oe));

   // -----------------------------------------------------------------
   // Clock, checking and closing
   // -----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR %0t ns: %s got %h expected %h", $time, what, got, exp);
         mismatches++;
      end
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp, input string what);
      logic [15:0] d;
      HOST.read_reg(a, d);
      chk(d, exp, what);
   endtask

   // Verdict lands two edges after the update edge, so three idle edges are ample
   task automatic pulse(input set_t r, input set_t f);
      @(posedge clock);
      raw_data  <= r;
      filt_data <= f;
      update    <= 1'b1;
      @(posedge clock);
      update <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   task automatic pins(input logic [3:0] exp, input string what);
      chk({12'h000, one_out, one_oe, two_out, two_oe}, {12'h000, exp}, what);
   endtask

   task automatic test_done();
      $display("TB: mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      $display("ERROR %0t ns: run limit reached", $time);
      mismatches++;
      test_done();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      row_t        r;
      set_t        rs, fs;
      logic [6:0]  adr [5];
      logic [15:0] msk [5];
      logic        pol, line;
      rst_b = 1'b0;
      update = 1'b0;
      raw_data = '0;
      filt_data = '0;
      mismatches = 0;
      cmp_count = 0;
      // Static rows: source, filter, channel, threshold, selected value, fill value, status
      rows[0]  = '{4'h1, 1'b0, 1'b0, 16'h8064, 14'h00C8, 14'h0000, 16'h0100};
      rows[1]  = '{4'h2, 1'b1, 1'b1, 16'h0064, 14'h0032, 14'h0800, 16'h0200};
      rows[2]  = '{4'h3, 1'b0, 1'b0, 16'h8064, 14'h0064, 14'h0800, 16'h0000};
      rows[3]  = '{4'h4, 1'b1, 1'b1, 16'h0000, 14'h3FFF, 14'h0000, 16'h0200};
      rows[4]  = '{4'h5, 1'b0, 1'b0, 16'hC064, 14'h0065, 14'h0000, 16'h0100};
      rows[5]  = '{4'h6, 1'b1, 1'b1, 16'h8064, 14'h0065, 14'h0000, 16'h0200};
      rows[6]  = '{4'h7, 1'b0, 1'b0, 16'h0064, 14'h0063, 14'h0800, 16'h0100};
      rows[7]  = '{4'h8, 1'b1, 1'b1, 16'h8000, 14'h0001, 14'h0000, 16'h0200};
      rows[8]  = '{4'h9, 1'b0, 1'b0, 16'h8000, 14'h3FFF, 14'h0000, 16'h0000};
      rows[9]  = '{4'hA, 1'b1, 1'b1, 16'h1FFF, 14'h2000, 14'h1FFF, 16'h0200};
      rows[10] = '{4'hB, 1'b0, 1'b0, 16'h8064, 14'h00C8, 14'h0000, 16'h0100};
      rows[11] = '{4'h0, 1'b0, 1'b0, 16'h8064, 14'h00C8, 14'h00C8, 16'h0000};
      rows[12] = '{4'hC, 1'b0, 1'b1, 16'h8064, 14'h00C8, 14'h00C8, 16'h0000};
      adr = '{THR1_OFS, THR2_OFS, SMP1_OFS, SMP2_OFS, CTRL_OFS};
      msk = '{THR_MASK, THR_MASK, SMP_MASK, SMP_MASK, CTRL_MASK};
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      pins(4'h0, "pins after reset");
      // Reset values, stored bits, status and unmapped places
      for (int i = 0; i < 5; i++) begin
         rd_chk(adr[i], REG_RESET, "reset value");
         HOST.write_reg(adr[i], 16'hFFFF);
         rd_chk(adr[i], msk[i], "stored bits");
         HOST.write_reg(adr[i], 16'h0000);
      end
      HOST.write_reg(7'h30, 16'hFFFF);
      rd_chk(7'h30, 16'h0000, "unmapped read");
      rd_chk(7'h27, 16'h0000, "odd address read");
      rd_chk(STATUS_OFS, 16'h0000, "status after reset");
      // Table of static comparisons
      foreach (rows[i]) begin
         r = rows[i];
         HOST.write_reg(r.ch2 ? THR2_OFS : THR1_OFS, r.thr);
         HOST.write_reg(CTRL_OFS, {r.ch2 ? r.src : 4'h0, r.ch2 ? 4'h0 : r.src, 3'b000, r.filt, 4'h0});
         rd_chk(STATUS_OFS, 16'h0000, "status before row");
         for (int k = 0; k < NUM_SRC; k++) begin
            rs[k] = r.other;
            fs[k] = r.other;
         end
         if (r.src != SRC_OFF && r.src <= SRC_LAST) begin
            if (r.filt)
               fs[r.src - 4'h1] = r.val;
            else
               rs[r.src - 4'h1] = r.val;
         end
         pulse(rs, fs);
         rd_chk(STATUS_OFS, r.exp, "static row status");
      end
      // Both channels at once with their own settings
      HOST.write_reg(THR1_OFS, 16'h8064);
      HOST.write_reg(THR2_OFS, 16'h0064);
      HOST.write_reg(CTRL_OFS, 16'h2100);
      rs = '0;
      rs[0] = 14'h00C8;
      rs[1] = 14'h00C8;
      pulse(rs, '0);
      rd_chk(STATUS_OFS, 16'h0100, "only channel one");
      rs[1] = 14'h0032;
      pulse(rs, '0);
      rd_chk(STATUS_OFS, 16'h0300, "both channels");
      // Pin enable, polarity and line select, with and without an alarm
      for (int m = 0; m < 4; m++) begin
         pol = m[1];
         line = m[0];
         HOST.write_reg(CTRL_OFS, {8'h01, 5'b00000, 1'b1, pol, line});
         rs = '0;
         rs[0] = 14'h00C8;
         pulse(rs, '0);
         pins(line ? {2'b00, pol, 1'b1} : {pol, 1'b1, 2'b00}, "pin active");
         pulse('0, '0);
         pins(line ? {2'b00, ~pol, 1'b1} : {~pol, 1'b1, 2'b00}, "pin idle");
      end
      HOST.write_reg(CTRL_OFS, 16'h0102);
      pulse(rs, '0);
      pins(4'h0, "pin disabled");
      // Sticky flag cleared by a read, set again only at the next update
      rd_chk(STATUS_OFS, 16'h0100, "flag set");
      rd_chk(STATUS_OFS, 16'h0000, "flag cleared by read");
      pulse(rs, '0);
      rd_chk(STATUS_OFS, 16'h0100, "flag set again");
      // Rate of change on both channels: deltas of ten average to ten; channel two tests below five.
      // Disabling first clears the history, so the next update only primes.
      HOST.write_reg(SMP1_OFS, 16'hFF02);
      rd_chk(SMP1_OFS, 16'h0002, "sample count");
      HOST.write_reg(SMP2_OFS, 16'h0002);
      HOST.write_reg(THR1_OFS, 16'h8005);
      HOST.write_reg(THR2_OFS, 16'h0005);
      HOST.write_reg(CTRL_OFS, 16'h0000);
      HOST.write_reg(CTRL_OFS, 16'h11C0);
      rd_chk(STATUS_OFS, 16'h0000, "clear before rate test");
      rs = '0;
      pulse(rs, '0);
      rs[0] = 14'h000A;
      pulse(rs, '0);
      rd_chk(STATUS_OFS, 16'h0000, "window incomplete");
      rs[0] = 14'h0014;
      pulse(rs, '0);
      rd_chk(STATUS_OFS, 16'h0100, "rate above threshold");
      pulse(rs, '0);
      pulse(rs, '0);
      rd_chk(STATUS_OFS, 16'h0200, "flat rate, only less-than alarm");
      test_done();
   end
endmodule // tb_top
